// ==== design/timer_unit_regs.vh ====
// Overview of operation
// - Timer 2 overflow sets bit 7 unless baud
// - Trigger edge with enable sets bit 6
// - Bit 5 picks timer 2 for receive clock
// - Bit 4 picks timer 2 for transmit clock
// - Bit 3 enables trigger capture or reload
// - Bit 2 runs or stops timer 2
// - Bit 1 selects pin events or core clock
// - Bit 0 capture or reload; baud forces reload
// - Timers 0 and 1 are byte pairs
// - Mode 0 is thirteen-bit counter, overflow flags
// - Count when run and gate or pin high
// - Starting a timer keeps its count
// - Timers advance every core clock or pin fall, no prescaler
// - Mode 1 uses all sixteen bits
// - Mode 2 reloads low byte from high byte
// - Timer 1 in mode 3 holds count
// - Split mode: high byte uses timer 1 controls
// - Timer 1 toggled by mode 3, baud usable
// - Timer 2 mode decoded from run, select bits
// - Autoreload on rollover or trigger edge
// - Capture copies count on trigger edge
// - Baud mode: no overflow flag, external flag works
// - Two-bit mode field selects timer mode
// - Timer 0 and 1 overflow flags cleared on interrupt vectoring
`ifndef TIMER_UNIT_REGS_VH
`define TIMER_UNIT_REGS_VH

`define ADDR_T01_CONTROL 8'h88
`define ADDR_T01_MODE 8'h89
`define ADDR_T0_COUNT_LOW 8'h8a
`define ADDR_T1_COUNT_LOW 8'h8b
`define ADDR_T0_COUNT_HIGH 8'h8c
`define ADDR_T1_COUNT_HIGH 8'h8d
`define ADDR_T2_CONTROL 8'hc8
`define ADDR_T2_RELOAD_LOW 8'hca
`define ADDR_T2_RELOAD_HIGH 8'hcb
`define ADDR_T2_COUNT_LOW 8'hcc
`define ADDR_T2_COUNT_HIGH 8'hcd

`define RESET_BYTE 8'h00

`define T2C_OVERFLOW 7
`define T2C_EXTERNAL 6
`define T2C_RX_SELECT 5
`define T2C_TX_SELECT 4
`define T2C_TRIGGER_ENABLE 3
`define T2C_RUN 2
`define T2C_FUNCTION 1
`define T2C_CAPTURE 0

`define T01C_T1_OVERFLOW 7
`define T01C_T1_RUN 6
`define T01C_T0_OVERFLOW 5
`define T01C_T0_RUN 4

`define T01M_T1_GATE 7
`define T01M_T1_FUNCTION 6
`define T01M_T1_MODE_HI 5
`define T01M_T1_MODE_LO 4
`define T01M_T0_GATE 3
`define T01M_T0_FUNCTION 2
`define T01M_T0_MODE_HI 1
`define T01M_T0_MODE_LO 0

`define MODE_13BIT 2'b00
`define MODE_16BIT 2'b01
`define MODE_AUTORELOAD 2'b10
`define MODE_SPLIT 2'b11

`define UART_MODE_1 2'b01
`define UART_MODE_3 2'b11

`endif

// ==== design/pin_edge_sync.v ====
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync #(
  parameter WIDTH = 6
) (
  input wire ref_clk,
  input wire reset_n,
  input wire [WIDTH-1:0] pinIn,
  output reg [WIDTH-1:0] pinLevel,
  output reg [WIDTH-1:0] pinFall
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  // Stage1 feeds only stage2; edges are taken from stage2 against pinLevel
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1 <= {WIDTH{1'b1}};
      stage2 <= {WIDTH{1'b1}};
      pinLevel <= {WIDTH{1'b1}};
      pinFall <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= pinIn;
      stage2 <= stage1;
      pinLevel <= stage2;
      pinFall <= pinLevel & ~stage2;
    end
  end
endmodule // pin_edge_sync
`default_nettype wire

// ==== design/triple_timer_counter_unit.v ====
`timescale 1ns/1ps
`default_nettype none
`include "timer_unit_regs.vh"
module triple_timer_counter_unit (
  input wire ref_clk,
  input wire reset_n,
  input wire [7:0] addr,
  input wire [7:0] wrData,
  input wire wrStrobe,
  input wire rdStrobe,
  output reg [7:0] rdData,
  input wire t0CountPin,
  input wire t1CountPin,
  input wire extIrq0Pin,
  input wire extIrq1Pin,
  input wire t2CountPin,
  input wire t2TriggerPin,
  input wire t0IrqAck,
  input wire t1IrqAck,
  input wire [1:0] uartMode,
  output reg t0OverflowFlag,
  output reg t1OverflowFlag,
  output reg t2IrqRequest,
  output reg rxBaudTick,
  output reg txBaudTick
);
  localparam PIN_T0 = 0;
  localparam PIN_T1 = 1;
  localparam PIN_IRQ0 = 2;
  localparam PIN_IRQ1 = 3;
  localparam PIN_T2 = 4;
  localparam PIN_TRIG = 5;

  wire [5:0] pinLevel;
  wire [5:0] pinFall;

  pin_edge_sync #(
    .WIDTH(6)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pinIn({t2TriggerPin, t2CountPin, extIrq1Pin, extIrq0Pin, t1CountPin, t0CountPin}),
    .pinLevel(pinLevel),
    .pinFall(pinFall)
  );

  reg [7:0] t0Low;
  reg [7:0] t0High;
  reg [7:0] t1Low;
  reg [7:0] t1High;
  reg [7:0] t01Mode;
  reg t0Run;
  reg t1Run;
  reg [7:0] t2Low;
  reg [7:0] t2High;
  reg [7:0] reloadCaptureLow;
  reg [7:0] reloadCaptureHigh;
  reg t2OverflowFlag;
  reg t2ExternalFlag;
  reg rxClockSourceSelect;
  reg txClockSourceSelect;
  reg triggerEnable;
  reg t2Run;
  reg t2FunctionSelect;
  reg captureReloadSelect;

  // One step of a timer byte pair in modes 0 to 2; mode 3 holds
  function [16:0] pairStep;
    input [1:0] mode;
    input [7:0] low;
    input [7:0] high;
    input enable;
    reg [16:0] r;
    begin
      r = {1'b0, high, low};
      if (enable)
      begin
        case (mode)
          `MODE_13BIT:
          begin
            r[4:0] = low[4:0] + 5'h01;
            if (low[4:0] == 5'h1f)
            begin
              r[15:8] = high + 8'h01;
              r[16] = (high == 8'hff);
            end
          end
          `MODE_16BIT:
          begin
            r[15:0] = {high, low} + 16'h0001;
            r[16] = &{high, low};
          end
          `MODE_AUTORELOAD:
          begin
            if (low == 8'hff)
            begin
              r[7:0] = high;
              r[16] = 1'b1;
            end
            else
            begin
              r[7:0] = low + 8'h01;
            end
          end
          default:
          begin
            r = {1'b0, high, low};
          end
        endcase
      end
      pairStep = r;
    end
  endfunction

  function isWrite;
    input [7:0] a;
    input [7:0] target;
    input strobe;
    begin
      isWrite = strobe && (a == target);
    end
  endfunction

  wire [1:0] t0Mode = t01Mode[`T01M_T0_MODE_HI:`T01M_T0_MODE_LO];
  wire [1:0] t1Mode = t01Mode[`T01M_T1_MODE_HI:`T01M_T1_MODE_LO];
  wire t0Split = (t0Mode == `MODE_SPLIT);

  // Counting is enabled per core clock or per pin falling edge, no prescaler
  wire t0Source = t01Mode[`T01M_T0_FUNCTION] ? pinFall[PIN_T0] : 1'b1;
  wire t1Source = t01Mode[`T01M_T1_FUNCTION] ? pinFall[PIN_T1] : 1'b1;
  wire t0Gate = ~t01Mode[`T01M_T0_GATE] | pinLevel[PIN_IRQ0];
  wire t1Gate = ~t01Mode[`T01M_T1_GATE] | pinLevel[PIN_IRQ1];
  wire t0Enable = t0Run & t0Gate & t0Source;
  // While timer 0 is split, timer 1 runs unless in its own mode 3
  wire t1RunTerm = t0Split ? 1'b1 : t1Run;
  wire t1Enable = t1RunTerm & t1Gate & t1Source & (t1Mode != `MODE_SPLIT);

  wire [16:0] t0Step = pairStep(t0Mode, t0Low, t0High, t0Enable);
  wire [16:0] t1Step = pairStep(t1Mode, t1Low, t1High, t1Enable);

  // Split mode: low byte on timer 0 controls, high byte on core clock and timer 1 run
  wire splitLowOvf = t0Enable & (t0Low == 8'hff);
  wire splitHighOvf = t1Run & (t0High == 8'hff);

  wire t0Ovf = t0Split ? splitLowOvf : t0Step[16];
  wire t1CountOvf = t1Step[16];
  wire t1FlagSet = t0Split ? splitHighOvf : t1CountOvf;

  // Timer 2 mode decode
  wire baudMode = rxClockSourceSelect | txClockSourceSelect;
  wire captureMode = captureReloadSelect & ~baudMode;
  wire t2Source = t2FunctionSelect ? pinFall[PIN_T2] : 1'b1;
  wire t2Enable = t2Run & t2Source;
  wire t2Ovf = t2Enable & ({t2High, t2Low} == 16'hffff);
  wire triggerEdge = triggerEnable & pinFall[PIN_TRIG];
  wire triggerAction = triggerEdge & ~baudMode;
  wire t2Reload = (t2Ovf & ~captureMode) | (triggerAction & ~captureMode);
  wire t2Capture = triggerAction & captureMode;
  wire [15:0] t2Inc = {t2High, t2Low} + 16'h0001;

  wire wrT01Control = isWrite(addr, `ADDR_T01_CONTROL, wrStrobe);
  wire wrT2Control = isWrite(addr, `ADDR_T2_CONTROL, wrStrobe);
  wire t2OvfSet = t2Ovf & ~baudMode;
  wire t2ExtSet = triggerEdge;

  reg next_t0OverflowFlag;
  reg next_t1OverflowFlag;
  reg next_t2OverflowFlag;
  reg next_t2ExternalFlag;

  // Hardware set wins over software write and interrupt acknowledge
  always @*
  begin
    next_t0OverflowFlag = t0OverflowFlag & ~t0IrqAck;
    next_t1OverflowFlag = t1OverflowFlag & ~t1IrqAck;
    next_t2OverflowFlag = t2OverflowFlag;
    next_t2ExternalFlag = t2ExternalFlag;
    if (wrT01Control)
    begin
      next_t0OverflowFlag = wrData[`T01C_T0_OVERFLOW];
      next_t1OverflowFlag = wrData[`T01C_T1_OVERFLOW];
    end
    if (wrT2Control)
    begin
      next_t2OverflowFlag = wrData[`T2C_OVERFLOW];
      next_t2ExternalFlag = wrData[`T2C_EXTERNAL];
    end
    if (t0Ovf)
    begin
      next_t0OverflowFlag = 1'b1;
    end
    if (t1FlagSet)
    begin
      next_t1OverflowFlag = 1'b1;
    end
    if (t2OvfSet)
    begin
      next_t2OverflowFlag = 1'b1;
    end
    if (t2ExtSet)
    begin
      next_t2ExternalFlag = 1'b1;
    end
  end

  wire baudUartMode = (uartMode == `UART_MODE_1) || (uartMode == `UART_MODE_3);

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      t0Low <= `RESET_BYTE;
      t0High <= `RESET_BYTE;
      t1Low <= `RESET_BYTE;
      t1High <= `RESET_BYTE;
      t01Mode <= `RESET_BYTE;
      t0Run <= 1'b0;
      t1Run <= 1'b0;
      t0OverflowFlag <= 1'b0;
      t1OverflowFlag <= 1'b0;
      t2Low <= `RESET_BYTE;
      t2High <= `RESET_BYTE;
      reloadCaptureLow <= `RESET_BYTE;
      reloadCaptureHigh <= `RESET_BYTE;
      t2OverflowFlag <= 1'b0;
      t2ExternalFlag <= 1'b0;
      rxClockSourceSelect <= 1'b0;
      txClockSourceSelect <= 1'b0;
      triggerEnable <= 1'b0;
      t2Run <= 1'b0;
      t2FunctionSelect <= 1'b0;
      captureReloadSelect <= 1'b0;
      t2IrqRequest <= 1'b0;
      rxBaudTick <= 1'b0;
      txBaudTick <= 1'b0;
      rdData <= `RESET_BYTE;
    end
    else
    begin
      // Timer 0 and 1 counts; a software write to a byte wins over counting
      if (t0Split)
      begin
        t0Low <= t0Enable ? t0Low + 8'h01 : t0Low;
        t0High <= t1Run ? t0High + 8'h01 : t0High;
      end
      else
      begin
        t0Low <= t0Step[7:0];
        t0High <= t0Step[15:8];
      end
      t1Low <= t1Step[7:0];
      t1High <= t1Step[15:8];
      if (isWrite(addr, `ADDR_T0_COUNT_LOW, wrStrobe))
      begin
        t0Low <= wrData;
      end
      if (isWrite(addr, `ADDR_T0_COUNT_HIGH, wrStrobe))
      begin
        t0High <= wrData;
      end
      if (isWrite(addr, `ADDR_T1_COUNT_LOW, wrStrobe))
      begin
        t1Low <= wrData;
      end
      if (isWrite(addr, `ADDR_T1_COUNT_HIGH, wrStrobe))
      begin
        t1High <= wrData;
      end
      if (isWrite(addr, `ADDR_T01_MODE, wrStrobe))
      begin
        t01Mode <= wrData;
      end
      // Run bits only gate counting, counts are untouched
      if (wrT01Control)
      begin
        t0Run <= wrData[`T01C_T0_RUN];
        t1Run <= wrData[`T01C_T1_RUN];
      end
      t0OverflowFlag <= next_t0OverflowFlag;
      t1OverflowFlag <= next_t1OverflowFlag;

      // Timer 2 count, reload and capture
      if (t2Reload)
      begin
        t2Low <= reloadCaptureLow;
        t2High <= reloadCaptureHigh;
      end
      else if (t2Enable)
      begin
        t2Low <= t2Inc[7:0];
        t2High <= t2Inc[15:8];
      end
      if (t2Capture)
      begin
        reloadCaptureLow <= t2Low;
        reloadCaptureHigh <= t2High;
      end
      if (isWrite(addr, `ADDR_T2_COUNT_LOW, wrStrobe))
      begin
        t2Low <= wrData;
      end
      if (isWrite(addr, `ADDR_T2_COUNT_HIGH, wrStrobe))
      begin
        t2High <= wrData;
      end
      if (isWrite(addr, `ADDR_T2_RELOAD_LOW, wrStrobe))
      begin
        reloadCaptureLow <= wrData;
      end
      if (isWrite(addr, `ADDR_T2_RELOAD_HIGH, wrStrobe))
      begin
        reloadCaptureHigh <= wrData;
      end
      if (wrT2Control)
      begin
        rxClockSourceSelect <= wrData[`T2C_RX_SELECT];
        txClockSourceSelect <= wrData[`T2C_TX_SELECT];
        triggerEnable <= wrData[`T2C_TRIGGER_ENABLE];
        t2Run <= wrData[`T2C_RUN];
        t2FunctionSelect <= wrData[`T2C_FUNCTION];
        captureReloadSelect <= wrData[`T2C_CAPTURE];
      end
      t2OverflowFlag <= next_t2OverflowFlag;
      t2ExternalFlag <= next_t2ExternalFlag;
      t2IrqRequest <= next_t2OverflowFlag | next_t2ExternalFlag;
      t0OverflowFlag <= next_t0OverflowFlag;

      // Serial clock ticks from timer 2 or timer 1 overflow
      rxBaudTick <= baudUartMode & (rxClockSourceSelect ? t2Ovf : t1CountOvf);
      txBaudTick <= baudUartMode & (txClockSourceSelect ? t2Ovf : t1CountOvf);

      // Read data stand in the cycle after the strobe only
      if (rdStrobe)
      begin
        case (addr)
          `ADDR_T01_CONTROL:
            rdData <= {t1OverflowFlag, t1Run, t0OverflowFlag, t0Run, 4'h0};
          `ADDR_T01_MODE:
            rdData <= t01Mode;
          `ADDR_T0_COUNT_LOW:
            rdData <= t0Low;
          `ADDR_T0_COUNT_HIGH:
            rdData <= t0High;
          `ADDR_T1_COUNT_LOW:
            rdData <= t1Low;
          `ADDR_T1_COUNT_HIGH:
            rdData <= t1High;
          `ADDR_T2_CONTROL:
            rdData <= {t2OverflowFlag, t2ExternalFlag, rxClockSourceSelect,
              txClockSourceSelect, triggerEnable, t2Run, t2FunctionSelect,
              captureReloadSelect};
          `ADDR_T2_RELOAD_LOW:
            rdData <= reloadCaptureLow;
          `ADDR_T2_RELOAD_HIGH:
            rdData <= reloadCaptureHigh;
          `ADDR_T2_COUNT_LOW:
            rdData <= t2Low;
          `ADDR_T2_COUNT_HIGH:
            rdData <= t2High;
          default:
            rdData <= `RESET_BYTE;
        endcase
      end
      else
      begin
        rdData <= `RESET_BYTE;
      end
    end
  end
endmodule // triple_timer_counter_unit
`default_nettype wire

// ==== bench/timer_unit_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module timer_unit_asserts (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [7:0] rdData,
  input wire logic t0IrqAck,
  input wire logic t1IrqAck,
  input wire logic [1:0] uartMode,
  input wire logic t0OverflowFlag,
  input wire logic t1OverflowFlag,
  input wire logic t2IrqRequest,
  input wire logic rxBaudTick,
  input wire logic txBaudTick
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  read_idle_zero_a: assert property (!$past(rdStrobe) |-> rdData == 8'h00)
    else $error("read data outside read cycle");
  unmapped_read_a: assert property (rdStrobe && addr == 8'h00 |=> rdData == 8'h00)
    else $error("unmapped read not zero");
  ctrl_low_zero_a: assert property (rdStrobe && addr == 8'h88 |=> rdData[3:0] == 4'h0)
    else $error("control low nibble not zero");
  ctrl_flags_seen_a: assert property (rdStrobe && addr == 8'h88 |=>
    rdData[7] == $past(t1OverflowFlag) && rdData[5] == $past(t0OverflowFlag))
    else $error("control read disagrees with flags");
  t2_req_read_a: assert property (rdStrobe && addr == 8'hc8 |=>
    (rdData[7] | rdData[6]) == $past(t2IrqRequest))
    else $error("timer 2 request disagrees with flags");
  t0_flag_clear_a: assert property ($fell(t0OverflowFlag) |->
    $past(t0IrqAck) || $past(wrStrobe) && $past(addr) == 8'h88)
    else $error("timer 0 flag cleared without cause");
  t1_flag_clear_a: assert property ($fell(t1OverflowFlag) |->
    $past(t1IrqAck) || $past(wrStrobe) && $past(addr) == 8'h88)
    else $error("timer 1 flag cleared without cause");
  t2_sw_clear_a: assert property ($fell(t2IrqRequest) |->
    $past(wrStrobe) && $past(addr) == 8'hc8)
    else $error("timer 2 flag cleared without write");
  rx_tick_mode_a: assert property (rxBaudTick |-> $past(uartMode[0]))
    else $error("receive tick in wrong serial mode");
  tx_tick_mode_a: assert property (txBaudTick |-> $past(uartMode[0]))
    else $error("transmit tick in wrong serial mode");
  cover property ($rose(t2IrqRequest));
  cover property (txBaudTick);
  cover property ($fell(t0OverflowFlag));
endmodule // timer_unit_asserts
bind triple_timer_counter_unit timer_unit_asserts timer_unit_asserts_i (
  .ref_clk, .reset_n, .addr, .wrStrobe, .rdStrobe, .rdData, .t0IrqAck,
  .t1IrqAck, .uartMode, .t0OverflowFlag, .t1OverflowFlag, .t2IrqRequest,
  .rxBaudTick, .txBaudTick
);
`default_nettype wire

// ==== bench/timer_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module timer_pin_model (
  input wire logic ref_clk,
  output logic t0CountPin,
  output logic t1CountPin,
  output logic extIrq0Pin,
  output logic extIrq1Pin,
  output logic t2CountPin,
  output logic t2TriggerPin
);
  // Gate 0 held low to block counting, gate 1 high to let it pass
  initial
  begin
    {t0CountPin, t1CountPin, t2CountPin, t2TriggerPin} = 4'hf;
    extIrq0Pin = 1'b0;
    extIrq1Pin = 1'b1;
  end
  // Low long enough to pass the synchroniser
  task automatic trigger_fall();
    @(posedge ref_clk);
    t2TriggerPin <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t2TriggerPin <= 1'b1;
  endtask
  // Each pulse stays low and high long enough to be seen once
  task automatic count_falls(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      t2CountPin <= 1'b0;
      repeat (4) @(posedge ref_clk);
      t2CountPin <= 1'b1;
      repeat (3) @(posedge ref_clk);
    end
  endtask
endmodule // timer_pin_model
`default_nettype wire

// ==== bench/triple_timer_counter_unit_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module triple_timer_counter_unit_tb;
  logic ref_clk = 0, reset_n = 0, wrStrobe = 0, rdStrobe = 0;
  logic [7:0] addr = 8'h00, wrData = 8'h00;
  logic [1:0] ack = 2'b00, uartMode = 2'b00;
  wire [7:0] rdData;
  wire t0CountPin, t1CountPin, extIrq0Pin, extIrq1Pin, t2CountPin, t2TriggerPin;
  wire t0OverflowFlag, t1OverflowFlag, t2IrqRequest, rxBaudTick, txBaudTick;
  int failures = 0, checks = 0, seed = 32'hd121, rxN = 0, txN = 0;
  triple_timer_counter_unit triple_timer_counter_unit_i (
    .ref_clk, .reset_n, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData,
    .t0CountPin, .t1CountPin, .extIrq0Pin, .extIrq1Pin, .t2CountPin,
    .t2TriggerPin, .t0IrqAck(ack[0]), .t1IrqAck(ack[1]), .uartMode,
    .t0OverflowFlag, .t1OverflowFlag, .t2IrqRequest, .rxBaudTick, .txBaudTick
  );
  timer_pin_model timer_pin_model_i (
    .ref_clk, .t0CountPin, .t1CountPin, .extIrq0Pin, .extIrq1Pin,
    .t2CountPin, .t2TriggerPin
  );
  initial
    forever #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    rxN += rxBaudTick;
    txN += txBaudTick;
  end
  task automatic chk(input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge ref_clk);
    wrStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge ref_clk);
    rdStrobe <= 1'b0;
    @(negedge ref_clk);
    d = rdData;
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(8'(a + 1), v[15:8]);
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    rd(a, v[7:0]);
    rd(8'(a + 1), v[15:8]);
  endtask
  // Reference for timers 0/1: returns {flag, high, low} after n counts
  function automatic logic [16:0] t01_model(input int t, m, hi, lo, n);
    int v;
    logic f;
    f = 1'b0;
    repeat (n)
    begin
      v = m == 0 ? (hi << 5 | lo & 31) + 1 : m == 1 ? (hi << 8 | lo) + 1 : lo + 1;
      if (m == 3 && t == 1)
        v = lo;
      if (v == (m == 0 ? 8192 : m == 1 ? 65536 : 256))
        f = 1'b1;
      if (m == 0)
        lo = lo & 224 | v & 31;
      if (m < 2)
        hi = m ? v >> 8 & 255 : v >> 5 & 255;
      lo = m == 2 && v == 256 ? hi : m == 0 ? lo : v & 255;
    end
    return {f, 8'(hi), 8'(lo)};
  endfunction
  function automatic logic [15:0] t2_model(input logic [15:0] c, r, input int n);
    repeat (n)
      c = c == 16'hffff ? r : c + 16'h1;
    return c;
  endfunction
  task automatic end_of_test();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #400000;
    failures++;
    end_of_test();
  end
  initial
  begin
    logic [7:0] d, hi, lo;
    logic [7:0] am [10];
    logic [7:0] tc [4];
    logic [16:0] e;
    logic [15:0] c, r, v;
    int t, m, k;
    am = '{8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h89, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'h00};
    tc = '{8'h09, 8'h08, 8'h01, 8'h1d};
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(8'hc8, d);
    chk(d, 8'h00);
    rd(8'h88, d);
    chk(d, 8'h00);
    foreach (am[i])
    begin
      rd(am[i], d);
      chk(d, 8'h00);
      hi = 8'($random(seed));
      wr(am[i], hi);
      rd(am[i], d);
      chk(d, am[i] != 8'h00 ? hi : 8'h00);
    end
    // Modes 0..3 on both timers, then gated off and gated on
    for (int i = 0; i < 10; i++)
    begin
      t = i % 2;
      m = i < 8 ? i / 2 : 0;
      hi = m == 2 ? 8'($random(seed)) : 8'hff;
      lo = 8'hf8 | (8'($random(seed)) & 8'h07);
      wr(8'h89, 8'((m | (i > 7 ? 8 : 0)) << 4 * t));
      wr(8'(8'h8c + t), hi);
      wr(8'(8'h8a + t), lo);
      @(posedge ref_clk) ack <= 2'b11;
      @(posedge ref_clk) ack <= 2'b00;
      wr(8'h88, 8'(16 << 2 * t));
      repeat (8) @(posedge ref_clk);
      e = t01_model(t, m, hi, lo, i == 8 ? 0 : 12);
      rd(8'h88, d);
      chk(d, 8'({e[16], 5'h0} << 2 * t | 16 << 2 * t));
      chk(t ? t1OverflowFlag : t0OverflowFlag, e[16]);
      wr(8'h88, 8'h00);
      rd(8'(8'h8c + t), d);
      chk(d, e[15:8]);
      rd(8'(8'h8a + t), d);
      chk(d & (m ? 8'hff : 8'h1f), e[7:0] & (m ? 8'hff : 8'h1f));
    end
    r = 16'($random(seed)) & 16'h7fff;
    wr16(8'hca, r);
    wr16(8'hcc, 16'hfffe);
    wr(8'hc8, 8'h04);
    repeat (8) @(posedge ref_clk);
    rd(8'hc8, d);
    chk(d, 8'h84);
    chk(t2IrqRequest, 1'b1);
    wr(8'hc8, 8'h00);
    rd16(8'hcc, v);
    chk(v, t2_model(16'hfffe, r, 12));
    foreach (tc[j])
    begin
      c = 16'($random(seed)) & 16'h7fff;
      r = 16'($random(seed));
      wr16(8'hcc, c);
      wr16(8'hca, r);
      wr(8'hc8, tc[j]);
      timer_pin_model_i.trigger_fall();
      repeat (4) @(posedge ref_clk);
      k = tc[j][3] && !tc[j][4];
      rd(8'hc8, d);
      chk(d, tc[j] | {1'b0, tc[j][3], 6'h0});
      rd16(8'hca, v);
      chk(v, k && tc[j][0] ? c : r);
      rd16(8'hcc, v);
      if (!tc[j][2])
        chk(v, k && !tc[j][0] ? r : c);
      wr(8'hc8, 8'h00);
    end
    // Counter function: only pin falls advance timer 2
    wr16(8'hcc, 16'h0000);
    wr(8'hc8, 8'h06);
    timer_pin_model_i.count_falls(5);
    wr(8'hc8, 8'h00);
    rd16(8'hcc, v);
    chk(v, 16'h0005);
    // Baud source: ticks only in serial modes 1 and 3
    wr16(8'hca, 16'hfffe);
    wr16(8'hcc, 16'hfffe);
    for (int u = 0; u < 4; u++)
    begin
      @(posedge ref_clk) uartMode <= 2'(u);
      wr(8'hc8, 8'h34);
      @(negedge ref_clk);
      rxN = 0;
      txN = 0;
      repeat (40) @(negedge ref_clk);
      chk(rxN > 15, u[0]);
      chk(txN > 15, u[0]);
      rd(8'hc8, d);
      chk(d, 8'h34);
      wr(8'hc8, 8'h00);
    end
    // Timer 1 in mode 2 with reload ff overflows every cycle
    wr(8'h89, 8'h20);
    wr(8'h8d, 8'hff);
    wr(8'h8b, 8'hff);
    wr(8'h88, 8'h40);
    @(negedge ref_clk);
    rxN = 0;
    txN = 0;
    repeat (20) @(negedge ref_clk);
    chk(rxN > 15, 1'b1);
    chk(txN > 15, 1'b1);
    wr(8'h88, 8'h00);
    @(negedge ref_clk);
    chk(t1OverflowFlag, 1'b1);
    @(posedge ref_clk) ack <= 2'b11;
    @(posedge ref_clk) ack <= 2'b00;
    @(negedge ref_clk);
    chk(t1OverflowFlag, 1'b0);
    end_of_test();
  end
endmodule // triple_timer_counter_unit_tb
`default_nettype wire
